// *** rtl/dcw_pkg.sv ***
// package for the drive control word decoder and unit scaling
// assumes a service-channel parameter write port and a comm-phase input
// What this block does
// - control bits 8-10 select operating mode
// - bit 13 low halts, high resumes
// - bit 14 disables or enables drive
// - control word writable only in CP2-CP4
// - error reset clears the latched error
// - error reset parameter 0..7, CP2-CP4 only
// - resolution is feed ratio times gear ratio
// - feed factors convert motor revolutions to units
// - gear ratio from motor and shaft revolutions
// - reading divided by resolution gives revolutions
// - rated current held in milliamperes as reference
// - other currents are thousandths of rated
// - status bits 8-10 echo active mode
// - modes map to position, velocity, torque
package dcw_pkg;
	localparam int CW_MODE_LSB = 8;
	localparam int CW_MODE_MSB = 10;
	localparam int CW_HALT_BIT = 13;
	localparam int CW_ENA_BIT = 14;
	localparam int CW_ON_BIT = 15;
	localparam logic [15:0] CW_RESET = 16'h0000;
	localparam logic [15:0] ERR_RST_RESET = 16'h0000;
	localparam logic [15:0] ERR_RST_MAX = 16'h0007;
	localparam int CURR_SCALE = 1000;
	localparam logic [31:0] FEED_NUM_RESET = 32'h0000_0001;
	localparam logic [31:0] FEED_DEN_RESET = 32'h0000_0001;
	localparam logic [31:0] GEAR_MOT_RESET = 32'h0000_0001;
	localparam logic [31:0] GEAR_SHAFT_RESET = 32'h0000_0001;
	localparam logic [31:0] RATED_MA_RESET = 32'h0000_0000;

	// parameter selector on the service channel port
	typedef enum logic [2:0] {
		DCW_P_CTRL = 3'b000,
		DCW_P_ERRRST = 3'b001,
		DCW_P_FEEDNUM = 3'b010,
		DCW_P_FEEDDEN = 3'b011,
		DCW_P_GEARMOT = 3'b100,
		DCW_P_GEARSH = 3'b101,
		DCW_P_RATED = 3'b110,
		DCW_P_NONE = 3'b111
	} dcw_param_e;

	typedef enum logic [2:0] {
		DCW_CP0 = 3'b000,
		DCW_CP1 = 3'b001,
		DCW_CP2 = 3'b010,
		DCW_CP3 = 3'b011,
		DCW_CP4 = 3'b100
	} dcw_phase_e;

	typedef enum logic [1:0] {
		DCW_M_CSP = 2'b00,
		DCW_M_CSV = 2'b01,
		DCW_M_CST = 2'b10,
		DCW_M_RSV = 2'b11
	} dcw_mode_e;

	typedef struct packed {
		logic        valid;
		dcw_param_e  sel;
		logic [31:0] data;
	} dcw_wr_s;

	typedef struct packed {
		logic      drive_on;
		logic      drive_en;
		logic      halt;
		dcw_mode_e mode;
	} dcw_ctrl_s;
endpackage

// *** rtl/dcw_decoder.sv ***
// drive control word decoder with unit and current scaling
// assumes writes arrive synchronous to i_sys_clk; one write per cycle at most
`timescale 1ns/1ps
module dcw_decoder
	import dcw_pkg::*;
#(
	parameter int POS_W = 32
) (
	input  wire logic              i_sys_clk,
	input  wire logic              i_rstn,
	input  wire dcw_wr_s           i_wr,
	input  wire dcw_phase_e        i_phase,
	input  wire logic              i_err_detected,
	input  wire logic [POS_W-1:0]  i_pos_rev,
	input  wire logic [15:0]       i_curr_permille,
	output logic                   o_wr_refused,
	output dcw_ctrl_s              o_ctrl,
	output logic [2:0]             o_mode_field,
	output logic [15:0]            o_status_mode,
	output logic                   o_fault_reset_transition,
	output logic                   o_err_latched,
	output logic [31:0]            o_err_rst_value,
	output logic [63:0]            o_resolution_num,
	output logic [63:0]            o_resolution_den,
	output logic [63:0]            o_pos_user,
	output logic [31:0]            o_rated_ma,
	output logic [31:0]            o_curr_ma
);
	logic [15:0] ctrl_word_r;
	logic [31:0] err_rst_r;
	logic [31:0] feed_num_r;
	logic [31:0] feed_den_r;
	logic [31:0] gear_mot_r;
	logic [31:0] gear_sh_r;
	logic [31:0] rated_r;
	logic        phase_ok;
	logic        wr_ok;
	logic [2:0]  mode_field;
	dcw_mode_e   mode_nxt;

	function automatic logic phase_writable(input dcw_phase_e ph);
		phase_writable = (ph == DCW_CP2) || (ph == DCW_CP3) || (ph == DCW_CP4);
	endfunction

	assign phase_ok = phase_writable(i_phase);
	assign wr_ok = i_wr.valid && phase_ok;
	// reserved bits 0-7, 11, 12 never read
	assign mode_field = ctrl_word_r[CW_MODE_MSB:CW_MODE_LSB];

	always_comb begin
		case (mode_field)
			3'b000: mode_nxt = DCW_M_CSP;
			3'b001: mode_nxt = DCW_M_CSV;
			3'b010: mode_nxt = DCW_M_CST;
			default: mode_nxt = DCW_M_RSV;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			ctrl_word_r <= CW_RESET;
		end else if (wr_ok && i_wr.sel == DCW_P_CTRL) begin
			ctrl_word_r <= i_wr.data[15:0];
		end
	end

	// out-of-range error reset values are refused, keeping 0..7
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			err_rst_r <= {16'h0000, ERR_RST_RESET};
			o_fault_reset_transition <= 1'b0;
		end else begin
			o_fault_reset_transition <= 1'b0;
			if (wr_ok && i_wr.sel == DCW_P_ERRRST && i_wr.data[15:0] <= ERR_RST_MAX) begin
				err_rst_r <= {16'h0000, i_wr.data[15:0]};
				o_fault_reset_transition <= 1'b1;
			end
		end
	end

	// set wins over the reset command in the same cycle
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			o_err_latched <= 1'b0;
		end else if (i_err_detected) begin
			o_err_latched <= 1'b1;
		end else if (wr_ok && i_wr.sel == DCW_P_ERRRST && i_wr.data[15:0] <= ERR_RST_MAX) begin
			o_err_latched <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			feed_num_r <= FEED_NUM_RESET;
			feed_den_r <= FEED_DEN_RESET;
			gear_mot_r <= GEAR_MOT_RESET;
			gear_sh_r <= GEAR_SHAFT_RESET;
			rated_r <= RATED_MA_RESET;
		end else if (wr_ok) begin
			case (i_wr.sel)
				DCW_P_FEEDNUM: feed_num_r <= i_wr.data;
				DCW_P_FEEDDEN: feed_den_r <= i_wr.data;
				DCW_P_GEARMOT: gear_mot_r <= i_wr.data;
				DCW_P_GEARSH: gear_sh_r <= i_wr.data;
				DCW_P_RATED: rated_r <= i_wr.data;
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			o_wr_refused <= 1'b0;
			o_ctrl <= '{drive_on: 1'b0, drive_en: 1'b0, halt: 1'b1, mode: DCW_M_CSP};
			o_mode_field <= 3'b000;
			o_status_mode <= 16'h0000;
			o_err_rst_value <= 32'h0000_0000;
			o_rated_ma <= 32'h0000_0000;
		end else begin
			o_wr_refused <= i_wr.valid && !phase_ok;
			o_ctrl.mode <= mode_nxt;
			o_ctrl.halt <= !ctrl_word_r[CW_HALT_BIT];
			o_ctrl.drive_en <= ctrl_word_r[CW_ENA_BIT];
			o_ctrl.drive_on <= ctrl_word_r[CW_ON_BIT];
			o_mode_field <= mode_field;
			o_status_mode <= {5'h00, mode_field, 8'h00};
			o_err_rst_value <= err_rst_r;
			o_rated_ma <= rated_r;
		end
	end

	// resolution kept as fraction; o_pos_user below still divides by the denominator
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			o_resolution_num <= 64'h0;
			o_resolution_den <= 64'h0;
			o_pos_user <= 64'h0;
			o_curr_ma <= 32'h0;
		end else begin
			o_resolution_num <= feed_num_r * gear_mot_r;
			o_resolution_den <= feed_den_r * gear_sh_r;
			// whole revolutions times resolution numerator over denominator
			o_pos_user <= 64'((feed_num_r * gear_mot_r * 64'(i_pos_rev)) / ((feed_den_r * gear_sh_r == 64'h0) ?
				64'h1 : 64'(feed_den_r) * 64'(gear_sh_r)));
			o_curr_ma <= 32'((64'(i_curr_permille) * 64'(rated_r)) / 64'(CURR_SCALE));
		end
	end

	property p_halt_follows;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(wr_ok && i_wr.sel == DCW_P_CTRL) |-> ##2 (o_ctrl.halt == !$past(i_wr.data[13], 2));
	endproperty
	a_halt_follows: assert property (p_halt_follows) else $error("halt bit mismatch");

	property p_enable_follows;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(wr_ok && i_wr.sel == DCW_P_CTRL) |-> ##2 (o_ctrl.drive_en == $past(i_wr.data[14], 2));
	endproperty
	a_enable_follows: assert property (p_enable_follows) else $error("enable bit mismatch");

	property p_on_follows;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(wr_ok && i_wr.sel == DCW_P_CTRL) |-> ##2 (o_ctrl.drive_on == $past(i_wr.data[15], 2));
	endproperty
	a_on_follows: assert property (p_on_follows) else $error("on bit mismatch");

	property p_mode_echo;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(wr_ok && i_wr.sel == DCW_P_CTRL) |-> ##2 (o_status_mode[10:8] == $past(i_wr.data[10:8], 2));
	endproperty
	a_mode_echo: assert property (p_mode_echo) else $error("status mode echo wrong");

	property p_mode_map;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(o_mode_field == 3'b001) |-> (o_ctrl.mode == DCW_M_CSV);
	endproperty
	a_mode_map: assert property (p_mode_map) else $error("mode map wrong");

	sequence s_bad_phase_wr;
		i_wr.valid && i_wr.sel == DCW_P_CTRL && !phase_ok;
	endsequence
	property p_phase_block;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		s_bad_phase_wr |=> $stable(ctrl_word_r) && o_wr_refused;
	endproperty
	a_phase_block: assert property (p_phase_block) else $error("write outside phase taken");

	property p_err_clear;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		o_fault_reset_transition && !$past(i_err_detected) |-> !o_err_latched;
	endproperty
	a_err_clear: assert property (p_err_clear) else $error("error not cleared");

	property p_err_range;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		1'b1 |-> (err_rst_r <= 32'(ERR_RST_MAX));
	endproperty
	a_err_range: assert property (p_err_range) else $error("error reset out of range");

	property p_resolution;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		$stable(feed_num_r) && $stable(gear_mot_r) |=> o_resolution_num == $past(feed_num_r) * $past(gear_mot_r);
	endproperty
	a_resolution: assert property (p_resolution) else $error("resolution numerator wrong");

	// a write inside the writable phases must never be flagged as refused
	sequence s_good_phase_wr;
		i_wr.valid && phase_ok;
	endsequence
	property p_no_false_refuse;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		s_good_phase_wr |=> !o_wr_refused;
	endproperty
	a_no_false_refuse: assert property (p_no_false_refuse) else $error("good write flagged refused");

	sequence s_err_rst_ok;
		wr_ok && i_wr.sel == DCW_P_ERRRST && i_wr.data[15:0] <= ERR_RST_MAX;
	endsequence
	property p_err_rst_taken;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		s_err_rst_ok |=> o_fault_reset_transition ##1 (o_err_rst_value[15:0] == $past(i_wr.data[15:0], 2));
	endproperty
	a_err_rst_taken: assert property (p_err_rst_taken) else $error("error reset not run");

	sequence s_err_rst_bad;
		wr_ok && i_wr.sel == DCW_P_ERRRST && i_wr.data[15:0] > ERR_RST_MAX;
	endsequence
	property p_err_rst_refused;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		s_err_rst_bad |=> !o_fault_reset_transition;
	endproperty
	a_err_rst_refused: assert property (p_err_rst_refused) else $error("out of range reset ran");

	property p_mode_reserved;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(o_mode_field > 3'b010) |-> (o_ctrl.mode == DCW_M_RSV);
	endproperty
	a_mode_reserved: assert property (p_mode_reserved) else $error("reserved mode not flagged");
endmodule

// *** tb/dcw_master.sv ***
// fieldbus master model: parameter writes over the service channel
// assumes the bench picks the comm phase and calls put() from one process
`timescale 1ns/1ps
module dcw_master
	import dcw_pkg::*;
(
	input  wire logic i_sys_clk,
	output dcw_wr_s   o_wr
);
	initial o_wr = '0;
	// launched after an edge, held through the taking edge, then released
	task automatic put(input dcw_param_e sel, input logic [31:0] data);
		@(posedge i_sys_clk);
		o_wr <= '{valid: 1'b1, sel: sel, data: data};
		@(posedge i_sys_clk);
		// released bus shows junk, not the old value
		o_wr <= '{valid: 1'b0, sel: DCW_P_NONE, data: ~data};
	endtask
endmodule

// *** tb/drive_control_word_and_unit_scaling_bench.sv ***
// self-checking bench for the control word decoder and unit scaling
// assumes the master model in dcw_master.sv; one clock, synchronous reset
`timescale 1ns/1ps
module drive_control_word_and_unit_scaling_bench
	import dcw_pkg::*;
;
	logic             i_sys_clk = 0, i_rstn = 0, i_err_detected = 0;
	dcw_wr_s          wr;
	dcw_phase_e       i_phase = DCW_CP2;
	logic [31:0]      i_pos_rev = '0;
	logic [15:0]      i_curr_permille = '0, w;
	logic             refused, frt, err_l;
	dcw_ctrl_s        ctrl;
	logic [2:0]       mode_f;
	logic [15:0]      st_mode;
	logic [31:0]      err_val, rated, curr, fn, fd, gm, gs, rm;
	logic [63:0]      res_n, res_d, pos_u;
	int               num_errors = 0, compares = 0, cyc = 0;
	always #5 i_sys_clk = ~i_sys_clk;
	dcw_master master (.i_sys_clk(i_sys_clk), .o_wr(wr));
	dcw_decoder DUT (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_wr(wr), .i_phase(i_phase),
		.i_err_detected(i_err_detected), .i_pos_rev(i_pos_rev), .i_curr_permille(i_curr_permille),
		.o_wr_refused(refused), .o_ctrl(ctrl), .o_mode_field(mode_f), .o_status_mode(st_mode),
		.o_fault_reset_transition(frt), .o_err_latched(err_l), .o_err_rst_value(err_val),
		.o_resolution_num(res_n), .o_resolution_den(res_d), .o_pos_user(pos_u),
		.o_rated_ma(rated), .o_curr_ma(curr));
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic dcw_ctrl_s exp_ctrl(input logic [15:0] c);
		dcw_mode_e m;
		m = (c[10:8] > 3'h2) ? DCW_M_RSV : dcw_mode_e'(c[9:8]);
		return '{drive_on: c[15], drive_en: c[14], halt: ~c[13], mode: m};
	endfunction
	task automatic end_sim();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic edges(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			end_sim();
		end
	end
	initial begin
		void'($urandom(52));
		edges(4);
		i_rstn <= 1'b1;
		edges(2);
		chk(ctrl, exp_ctrl(16'h0000));
		chk(res_n, 64'h1);
		// every mode code, reserved bits random
		for (int m = 0; m < 8; m++) begin
			w = 16'($urandom);
			w[10:8] = 3'(m);
			i_phase <= dcw_phase_e'(2 + $urandom % 3);
			master.put(DCW_P_CTRL, {16'h0000, w});
			edges(2);
			chk(ctrl, exp_ctrl(w));
			chk(mode_f, w[10:8]);
			chk(st_mode, {5'h00, w[10:8], 8'h00});
		end
		// write outside the writable phases is refused
		i_phase <= DCW_CP1;
		master.put(DCW_P_CTRL, 32'h0000_0000);
		// refusal flag stands one cycle only, right after the taking edge
		#1;
		chk(refused, 1'b1);
		edges(1);
		chk(ctrl, exp_ctrl(w));
		i_phase <= DCW_CP4;
		// error latch, then reset command; out-of-range value ignored
		i_err_detected <= 1'b1;
		edges(1);
		i_err_detected <= 1'b0;
		edges(1);
		chk(err_l, 1'b1);
		master.put(DCW_P_ERRRST, 32'h7);
		#1;
		chk(frt, 1'b1);
		chk(err_l, 1'b0);
		edges(1);
		chk(err_val, 32'h7);
		master.put(DCW_P_ERRRST, 32'h8);
		#1;
		chk(frt, 1'b0);
		edges(1);
		chk(err_val, 32'h7);
		// scaling: fixed example first, then random factors
		for (int k = 0; k < 5; k++) begin
			fn = (k == 0) ? 32'd360000 : $urandom % 100000 + 1;
			fd = (k == 0) ? 32'd1 : $urandom % 100 + 1;
			gm = (k == 0) ? 32'd1 : $urandom % 100 + 1;
			gs = (k == 0) ? 32'd1 : $urandom % 100 + 1;
			master.put(DCW_P_FEEDNUM, fn);
			master.put(DCW_P_FEEDDEN, fd);
			master.put(DCW_P_GEARMOT, gm);
			master.put(DCW_P_GEARSH, gs);
			rm = (k == 0) ? 32'd20000 : $urandom % 65535 + 1;
			master.put(DCW_P_RATED, rm);
			i_pos_rev <= (k == 0) ? 32'd2 : $urandom % 1000;
			i_curr_permille <= (k == 0) ? 16'd750 : 16'($urandom % 2001);
			edges(5);
			chk(res_n, 64'(fn) * 64'(gm));
			chk(res_d, 64'(fd) * 64'(gs));
			chk(pos_u, 64'(i_pos_rev) * 64'(fn) * 64'(gm) / (64'(fd) * 64'(gs)));
			chk(curr, 32'(64'(i_curr_permille) * 64'(rm) / 64'd1000));
			chk(rated, rm);
			if (k == 0) begin
				chk(pos_u, 64'd720000);
				chk(curr, 32'd15000);
			end
		end
		chk(rated != 32'h0, 1'b1);
		end_sim();
	end
endmodule
